/* core/sfspi_top.sv */
// Serial flash SPI pin front end with APB register access
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module sfspi_top #(
   parameter int unsigned FIFO_DEPTH = sfspi_pkg::RX_FIFO_DEPTH,
   parameter int unsigned FIFO_WIDTH = sfspi_pkg::RX_FIFO_WIDTH
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic        hold_n,
   input  wire logic        wp_n,
   input  wire logic        serial_in_dual_io_zero_in,
   output logic             serial_in_dual_io_zero_out,
   output logic             serial_in_dual_io_zero_oe_n,
   output logic             so_out,
   output logic             so_oe_n,
   input  wire logic        core_busy,
   output logic             standby,
   output logic             array_hw_locked
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   localparam int unsigned NPIN = 5;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1;
   logic [NPIN-1:0] sync2;
   logic            sck_s;
   logic            cs_n_s;
   logic            hold_n_s;
   logic            wp_n_s;
   logic            si_s;

   assign pin_raw = {sck, cs_n, hold_n, wp_n, serial_in_dual_io_zero_in};
   assign {sck_s, cs_n_s, hold_n_s, wp_n_s, si_s} = sync2;

   // Reset low so select must be seen high before any falling edge counts
   for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sync1[i] <= 1'b0;
            sync2[i] <= 1'b0;
         end else begin
            sync1[i] <= pin_raw[i];
            sync2[i] <= sync1[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoding
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == sfspi_pkg::REG_CTRL)   || (a == sfspi_pkg::REG_STATUS) ||
             (a == sfspi_pkg::REG_RXDATA) || (a == sfspi_pkg::REG_TXDATA) ||
             (a == sfspi_pkg::REG_SREG)   || (a == sfspi_pkg::REG_OPCODE);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State
   sfspi_pkg::sfspi_state_t state, next_state;
   logic        sck_q, next_sck_q;
   logic        cs_q, next_cs_q;
   logic        seen_high, next_seen_high;
   logic        hold, next_hold;
   logic [7:0]  rx_sh, next_rx_sh;
   logic [2:0]  rx_cnt, next_rx_cnt;
   logic [2:0]  byte_idx, next_byte_idx;
   logic [7:0]  opcode, next_opcode;
   logic [7:0]  tx_sh, next_tx_sh;
   logic [7:0]  tx_hold, next_tx_hold;
   logic        tx_full, next_tx_full;
   logic [1:0]  dcnt, next_dcnt;
   logic [7:0]  rx_hold, next_rx_hold;
   logic        rx_pend, next_rx_pend;
   logic        overrun, next_overrun;
   logic        status_write_lock_bit, next_srp;
   logic [3:0]  bp, next_bp;
   logic        ctrl_en, next_ctrl_en;
   logic        so_q, next_so_q;
   logic        so_oe_q, next_so_oe_q;
   logic        io0_q, next_io0_q;
   logic        io0_oe_q, next_io0_oe_q;
   logic        standby_q, next_standby_q;
   logic        hwlock_q, next_hwlock_q;
   logic        hwprot_q, next_hwprot_q;
   logic [31:0] prdata_q, next_prdata_q;
   logic        pready_q, next_pready_q;
   logic        pslverr_q, next_pslverr_q;

   logic                  fifo_in_ready;
   logic [FIFO_WIDTH-1:0] fifo_out_data;
   logic                  fifo_out_valid;
   logic                  fifo_pop;

   logic        active;
   logic        rise;
   logic        fall;
   logic        apb_done;
   logic        wr_lock;
   logic        ovr_set;
   logic [7:0]  in_byte;
   logic [7:0]  ld;
   logic [31:0] status_word;

   sfspi_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_data   (FIFO_WIDTH'(rx_hold)),
      .in_valid  (rx_pend),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop)
   );

   // Serial clock edges count only while selected, armed and not paused
   assign active  = !cs_n_s && !hold && (state != sfspi_pkg::ST_IDLE);
   assign rise    = active && sck_s && !sck_q;
   assign fall    = active && !sck_s && sck_q;
   assign in_byte = {rx_sh[6:0], si_s};
   assign wr_lock = status_write_lock_bit && !wp_n_s;
   assign apb_done = psel && penable && pready_q;
   assign fifo_pop = apb_done && !pwrite && (paddr == sfspi_pkg::REG_RXDATA);

   always_comb begin
      status_word = '0;
      status_word[sfspi_pkg::ST_SEL_BIT]    = !cs_n_s;
      status_word[sfspi_pkg::ST_HOLD_BIT]   = hold;
      status_word[sfspi_pkg::ST_DUAL_BIT]   = (state == sfspi_pkg::ST_DUAL_OUT);
      status_word[sfspi_pkg::ST_RXV_BIT]    = fifo_out_valid;
      status_word[sfspi_pkg::ST_TXF_BIT]    = tx_full;
      status_word[sfspi_pkg::ST_LOCK_BIT]   = hwlock_q;
      status_word[sfspi_pkg::ST_ARMED_BIT]  = seen_high;
      status_word[sfspi_pkg::ST_OVR_BIT]    = overrun;
      status_word[sfspi_pkg::ST_HWPROT_BIT] = hwprot_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_state     = state;
      next_sck_q     = sck_s;
      next_cs_q      = cs_n_s;
      next_seen_high = seen_high;
      next_hold      = hold;
      next_rx_sh     = rx_sh;
      next_rx_cnt    = rx_cnt;
      next_byte_idx  = byte_idx;
      next_opcode    = opcode;
      next_tx_sh     = tx_sh;
      next_tx_hold   = tx_hold;
      next_tx_full   = tx_full;
      next_dcnt      = dcnt;
      next_rx_hold   = rx_hold;
      next_rx_pend   = rx_pend && !fifo_in_ready;
      next_overrun   = overrun;
      next_srp       = status_write_lock_bit;
      next_bp        = bp;
      next_ctrl_en   = ctrl_en;
      next_so_q      = so_q;
      next_io0_q     = io0_q;
      ld             = tx_full ? tx_hold : sfspi_pkg::IDLE_FILL;
      ovr_set        = 1'b0;

      // Pause follows the pin only while the clock sits low
      if (cs_n_s) begin
         next_hold = 1'b0;
      end else if (!sck_s) begin
         next_hold = !hold_n_s;
      end

      if (cs_n_s) begin
         next_seen_high = 1'b1;
      end

      if (rise && state != sfspi_pkg::ST_DUAL_OUT) begin
         next_rx_sh  = in_byte;
         next_rx_cnt = rx_cnt + 1'b1;
         if (rx_cnt == sfspi_pkg::LAST_BIT) begin
            // Full byte: hand to the FIFO; while a byte still waits, the new byte is lost
            if (next_rx_pend) begin
               next_overrun = 1'b1;
               ovr_set      = 1'b1;
            end else begin
               next_rx_hold = in_byte;
               next_rx_pend = 1'b1;
            end
            if (byte_idx != sfspi_pkg::IDX_MAX) begin
               next_byte_idx = byte_idx + 1'b1;
            end
            case (state)
               sfspi_pkg::ST_OPCODE: begin
                  next_opcode   = in_byte;
                  next_byte_idx = '0;
                  if (in_byte == sfspi_pkg::OP_DUAL_READ) begin
                     next_state = sfspi_pkg::ST_DUAL_HDR;
                  end else begin
                     next_state = sfspi_pkg::ST_BODY;
                  end
               end
               sfspi_pkg::ST_DUAL_HDR: begin
                  if (byte_idx == sfspi_pkg::DUAL_HDR_BYTES - 3'h1) begin
                     next_state = sfspi_pkg::ST_DUAL_OUT;
                     next_dcnt  = '0;
                  end
               end
               sfspi_pkg::ST_BODY: begin
                  if (opcode == sfspi_pkg::OP_WRITE_STATUS && byte_idx == '0 &&
                      !wr_lock) begin
                     next_srp = in_byte[sfspi_pkg::SREG_SRP_BIT];
                     next_bp  = in_byte[sfspi_pkg::SREG_BP_MSB:sfspi_pkg::SREG_BP_LSB];
                  end
               end
               default: begin
               end
            endcase
         end
      end

      if (fall) begin
         if (state == sfspi_pkg::ST_DUAL_OUT) begin
            // Two bits per falling edge, high bit on the output pin
            if (dcnt == '0) begin
               next_so_q    = ld[7];
               next_io0_q   = ld[6];
               next_tx_sh   = {ld[5:0], 2'b00};
               next_tx_full = 1'b0;
            end else begin
               next_so_q  = tx_sh[7];
               next_io0_q = tx_sh[6];
               next_tx_sh = {tx_sh[5:0], 2'b00};
            end
            next_dcnt = (dcnt == sfspi_pkg::LAST_PAIR) ? '0 : dcnt + 1'b1;
         end else if (rx_cnt == '0) begin
            next_so_q  = ld[7];
            next_tx_sh = {ld[6:0], 1'b0};
            if (state == sfspi_pkg::ST_BODY) begin
               next_tx_full = 1'b0;
            end
         end else begin
            next_so_q  = tx_sh[7];
            next_tx_sh = {tx_sh[6:0], 1'b0};
         end
      end

      // Selection starts only on a seen high-to-low select edge
      if (state == sfspi_pkg::ST_IDLE && !cs_n_s && cs_q && seen_high &&
          ctrl_en) begin
         next_state    = sfspi_pkg::ST_OPCODE;
         next_rx_cnt   = '0;
         next_byte_idx = '0;
      end

      // Deselect resets the interface, including during a pause
      if (cs_n_s) begin
         next_state  = sfspi_pkg::ST_IDLE;
         next_rx_cnt = '0;
         next_dcnt   = '0;
      end

      // Register writes land at the completing edge
      if (apb_done && pwrite) begin
         case (paddr)
            sfspi_pkg::REG_CTRL: begin
               next_ctrl_en = pwdata[sfspi_pkg::CTRL_EN_BIT];
               // A new overrun in the same cycle beats the clear
               if (pwdata[sfspi_pkg::CTRL_OVR_CLR] && !ovr_set) begin
                  next_overrun = 1'b0;
               end
            end
            sfspi_pkg::REG_TXDATA: begin
               next_tx_hold = pwdata[7:0];
               next_tx_full = 1'b1;
            end
            sfspi_pkg::REG_SREG: begin
               if (!wr_lock) begin
                  next_srp = pwdata[sfspi_pkg::SREG_SRP_BIT];
                  next_bp  = pwdata[sfspi_pkg::SREG_BP_MSB:sfspi_pkg::SREG_BP_LSB];
               end
            end
            default: begin
            end
         endcase
      end

      next_so_oe_q  = !(!cs_n_s && !next_hold &&
                        (next_state == sfspi_pkg::ST_BODY ||
                         next_state == sfspi_pkg::ST_DUAL_OUT));
      next_io0_oe_q = !(!cs_n_s && !next_hold &&
                        next_state == sfspi_pkg::ST_DUAL_OUT);
      // Internal cycles run on through deselect; standby waits for them
      next_standby_q = cs_n_s && !core_busy;
      next_hwlock_q  = wr_lock;
      next_hwprot_q  = wr_lock && (bp != '0);

      // One wait state so every bus output comes from a flop
      next_pready_q  = psel && penable && !pready_q;
      next_pslverr_q = pslverr_q;
      next_prdata_q  = prdata_q;
      if (psel && penable && !pready_q) begin
         next_pslverr_q = !is_mapped(paddr);
         next_prdata_q  = '0;
         if (!pwrite) begin
            case (paddr)
               sfspi_pkg::REG_CTRL:   next_prdata_q[sfspi_pkg::CTRL_EN_BIT] = ctrl_en;
               sfspi_pkg::REG_STATUS: next_prdata_q = status_word;
               sfspi_pkg::REG_RXDATA: begin
                  // Empty queue reads as zero, never stale storage
                  if (fifo_out_valid) begin
                     next_prdata_q[7:0] = 8'(fifo_out_data);
                  end
               end
               sfspi_pkg::REG_TXDATA: next_prdata_q[7:0] = tx_hold;
               sfspi_pkg::REG_SREG: begin
                  next_prdata_q[sfspi_pkg::SREG_SRP_BIT] = status_write_lock_bit;
                  next_prdata_q[sfspi_pkg::SREG_BP_MSB:sfspi_pkg::SREG_BP_LSB] = bp;
               end
               sfspi_pkg::REG_OPCODE: next_prdata_q[7:0] = opcode;
               default:               next_prdata_q = '0;
            endcase
         end
      end else if (!psel) begin
         next_pslverr_q = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= sfspi_pkg::ST_IDLE;
         sck_q     <= 1'b0;
         cs_q      <= 1'b0;
         seen_high <= 1'b0;
         hold      <= 1'b0;
         rx_sh     <= '0;
         rx_cnt    <= '0;
         byte_idx  <= '0;
         opcode    <= '0;
         tx_sh     <= '0;
         tx_hold   <= '0;
         tx_full   <= 1'b0;
         dcnt      <= '0;
         rx_hold   <= '0;
         rx_pend   <= 1'b0;
         overrun   <= 1'b0;
         status_write_lock_bit       <= sfspi_pkg::SRP_RST;
         bp        <= sfspi_pkg::BP_RST;
         ctrl_en   <= sfspi_pkg::CTRL_EN_RST;
         so_q      <= 1'b0;
         so_oe_q   <= 1'b1;
         io0_q     <= 1'b0;
         io0_oe_q  <= 1'b1;
         standby_q <= 1'b0;
         hwlock_q  <= 1'b0;
         hwprot_q  <= 1'b0;
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         state     <= next_state;
         sck_q     <= next_sck_q;
         cs_q      <= next_cs_q;
         seen_high <= next_seen_high;
         hold      <= next_hold;
         rx_sh     <= next_rx_sh;
         rx_cnt    <= next_rx_cnt;
         byte_idx  <= next_byte_idx;
         opcode    <= next_opcode;
         tx_sh     <= next_tx_sh;
         tx_hold   <= next_tx_hold;
         tx_full   <= next_tx_full;
         dcnt      <= next_dcnt;
         rx_hold   <= next_rx_hold;
         rx_pend   <= next_rx_pend;
         overrun   <= next_overrun;
         status_write_lock_bit       <= next_srp;
         bp        <= next_bp;
         ctrl_en   <= next_ctrl_en;
         so_q      <= next_so_q;
         so_oe_q   <= next_so_oe_q;
         io0_q     <= next_io0_q;
         io0_oe_q  <= next_io0_oe_q;
         standby_q <= next_standby_q;
         hwlock_q  <= next_hwlock_q;
         hwprot_q  <= next_hwprot_q;
         prdata_q  <= next_prdata_q;
         pready_q  <= next_pready_q;
         pslverr_q <= next_pslverr_q;
      end
   end

   assign prdata                      = prdata_q;
   assign pready                      = pready_q;
   assign pslverr                     = pslverr_q;
   assign so_out                      = so_q;
   assign so_oe_n                     = so_oe_q;
   assign serial_in_dual_io_zero_out  = io0_q;
   assign serial_in_dual_io_zero_oe_n = io0_oe_q;
   assign standby                     = standby_q;
   assign array_hw_locked             = hwprot_q;
endmodule

/* core/sfspi_pkg.sv */
// Constants, register map and state encoding for the serial flash pin front end
package sfspi_pkg;

   // Instruction codes the front end reacts to
   localparam logic [7:0] OP_DUAL_READ    = 8'h3b;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;

   // Address bytes plus dummy byte ahead of dual output data
   localparam logic [2:0] DUAL_HDR_BYTES  = 3'h4;
   localparam logic [7:0] IDLE_FILL       = 8'hff;
   localparam logic [2:0] LAST_BIT        = 3'h7;
   localparam logic [1:0] LAST_PAIR       = 2'h3;
   localparam logic [2:0] IDX_MAX         = 3'h7;

   localparam int unsigned RX_FIFO_DEPTH  = 32;
   localparam int unsigned RX_FIFO_WIDTH  = 8;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_RXDATA = 8'h08;
   localparam logic [7:0] REG_TXDATA = 8'h0c;
   localparam logic [7:0] REG_SREG   = 8'h10;
   localparam logic [7:0] REG_OPCODE = 8'h14;

   // Field positions
   localparam int unsigned CTRL_EN_BIT    = 0;
   localparam int unsigned CTRL_OVR_CLR   = 1;
   localparam int unsigned ST_SEL_BIT     = 0;
   localparam int unsigned ST_HOLD_BIT    = 1;
   localparam int unsigned ST_DUAL_BIT    = 2;
   localparam int unsigned ST_RXV_BIT     = 3;
   localparam int unsigned ST_TXF_BIT     = 4;
   localparam int unsigned ST_LOCK_BIT    = 5;
   localparam int unsigned ST_ARMED_BIT   = 6;
   localparam int unsigned ST_OVR_BIT     = 7;
   localparam int unsigned ST_HWPROT_BIT  = 8;
   localparam int unsigned SREG_SRP_BIT   = 7;
   localparam int unsigned SREG_BP_LSB    = 2;
   localparam int unsigned SREG_BP_MSB    = 5;

   // Reset values
   localparam logic       CTRL_EN_RST = 1'b1;
   localparam logic       SRP_RST     = 1'b0;
   localparam logic [3:0] BP_RST      = 4'h0;

   typedef enum logic [4:0] {
      ST_IDLE     = 5'h01,
      ST_OPCODE   = 5'h02,
      ST_BODY     = 5'h04,
      ST_DUAL_HDR = 5'h08,
      ST_DUAL_OUT = 5'h10
   } sfspi_state_t;

endpackage

/* core/sfspi_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sfspi_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_idx;
   logic [AW-1:0]    rd_idx;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_idx;
   logic [AW-1:0]    next_rd_idx;
   logic [AW:0]      next_count;
   logic             do_wr;
   logic             do_rd;

   assign in_ready  = (count != FULL_CNT);
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_idx];

   always_comb begin
      do_wr       = in_valid & in_ready;
      do_rd       = out_valid & out_ready;
      next_wr_idx = wr_idx;
      next_rd_idx = rd_idx;
      next_count  = count;
      if (do_wr) begin
         next_wr_idx = (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
      end
      if (do_rd) begin
         next_rd_idx = (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
      end
      if (do_wr && !do_rd) begin
         next_count = count + 1'b1;
      end else if (do_rd && !do_wr) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count  <= '0;
      end else begin
         wr_idx <= next_wr_idx;
         rd_idx <= next_rd_idx;
         count  <= next_count;
      end
   end

   // Storage needs no reset; only entries below count are ever read out
   always_ff @(posedge pclk) begin
      if (do_wr) begin
         mem[wr_idx] <= in_data;
      end
   end
endmodule

/* sim/sfspi_master.sv */
// Serial bus master model driving the pins in clock mode 0
`timescale 1ns/100ps
module sfspi_master (
   input  wire logic pclk,
   input  wire logic so_w,
   input  wire logic io0_w,
   output logic      sck,
   output logic      cs_n,
   output logic      mosi
);
   // Select starts low, so the first frame has no select edge before it
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
      mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic sel(input logic v);
      tick(1);
      cs_n <= v;
      tick(8);
   endtask
   // Four clocks a half period gives the 320 ns serial clock
   task automatic xb(input logic [7:0] tx, output logic [7:0] rs, output logic [7:0] ri);
      for (int i = 7; i >= 0; i--) begin
         tick(1);
         mosi <= tx[i];
         tick(3);
         sck <= 1'b1;
         rs[i] = so_w;
         ri[i] = io0_w;
         tick(4);
         sck <= 1'b0;
      end
   endtask
endmodule

/* sim/sfspi_sva.sv */
// Checker on the ports of the serial flash front end
`timescale 1ns/100ps
module sfspi_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic so_out,
   input wire logic so_oe_n,
   input wire logic serial_in_dual_io_zero_oe_n,
   input wire logic core_busy,
   input wire logic standby,
   input wire logic array_hw_locked
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_oe_desel: assert property ($rose(cs_n) |-> ##[1:4] so_oe_n)
      else $error("serial output still driven after deselect");
   a_io0_desel: assert property ($rose(cs_n) |-> ##[1:4] serial_in_dual_io_zero_oe_n)
      else $error("second output still driven after deselect");
   a_io0_sel: assert property ($fell(serial_in_dual_io_zero_oe_n) |-> !cs_n)
      else $error("second output driven while deselected");
   a_pause_off: assert property ((!hold_n) [*8] |-> so_oe_n)
      else $error("serial output driven during pause");
   a_out_fall: assert property (!so_oe_n && $past(!so_oe_n) && $changed(so_out) |-> !sck)
      else $error("serial output changed while clock high");
   a_busy_wake: assert property (core_busy |=> !standby)
      else $error("standby while internal cycle runs");
   a_lock_wp: assert property (wp_n [*4] |-> !array_hw_locked)
      else $error("array locked with protect pin high");
   a_apb_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle into access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
endmodule
bind sfspi_top sfspi_sva sva_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
   .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n),
   .serial_in_dual_io_zero_oe_n(serial_in_dual_io_zero_oe_n), .core_busy(core_busy),
   .standby(standby), .array_hw_locked(array_hw_locked));

/* sim/tb.sv */
// Testbench for the serial flash pin front end
`timescale 1ns/100ps
`define CK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
   logic        pclk, presetn, psel, penable, pwrite, hold_n, wp_n, core_busy, err;
   logic        pready, pslverr, sck, cs_n, mosi, io0_o, io0_oe_n, so_o, so_oe_n;
   logic        standby, hw_lk;
   logic [7:0]  paddr, rs, ri;
   logic [31:0] pwdata, prdata, q;
   int          n_fail = 0;
   int          samples_checked = 0;
   // Pull-up on the output line; the input line falls to the master when released
   wire         so_w = so_oe_n ? 1'b1 : so_o;
   wire         io0_w = io0_oe_n ? mosi : io0_o;
   sfspi_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck(sck), .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n),
      .serial_in_dual_io_zero_in(io0_w), .serial_in_dual_io_zero_out(io0_o),
      .serial_in_dual_io_zero_oe_n(io0_oe_n), .so_out(so_o), .so_oe_n(so_oe_n),
      .core_busy(core_busy), .standby(standby), .array_hw_locked(hw_lk));
   sfspi_master m_u (.pclk(pclk), .so_w(so_w), .io0_w(io0_w), .sck(sck), .cs_n(cs_n),
      .mosi(mosi));
   task automatic test_done();
      $display("checks=%0d errors=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Waits as long as the slave needs; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      ap(1'b0, a, 32'h0);
      `CK(q, e)
   endtask
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // Longest path is about 3600 clocks
   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      test_done();
   end
   initial begin
      {presetn, psel, penable, pwrite, core_busy} = 5'h0;
      {hold_n, wp_n} = 2'h3;
      {paddr, pwdata} = 40'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk(sfspi_pkg::REG_CTRL, 32'h1);
      chk(sfspi_pkg::REG_SREG, 32'h0);
      ap(1'b0, 8'h40, 32'h0);
      `CK({err, q}, 33'h100000000)
      m_u.xb(8'ha5, rs, ri);
      chk(sfspi_pkg::REG_RXDATA, 32'h0);
      m_u.sel(1'b1);
      m_u.sel(1'b0);
      ap(1'b1, sfspi_pkg::REG_TXDATA, 32'h96);
      m_u.xb(8'h0b, rs, ri);
      m_u.xb(8'h5a, rs, ri);
      `CK(rs, 8'h96)
      m_u.sel(1'b1);
      chk(sfspi_pkg::REG_RXDATA, 32'h0b);
      chk(sfspi_pkg::REG_RXDATA, 32'h5a);
      chk(sfspi_pkg::REG_OPCODE, 32'h0b);
      m_u.sel(1'b0);
      for (int i = 0; i < 34; i++) m_u.xb(i[7:0], rs, ri);
      m_u.sel(1'b1);
      ap(1'b0, sfspi_pkg::REG_STATUS, 32'h0);
      `CK(q[7], 1'b1)
      ap(1'b1, sfspi_pkg::REG_CTRL, 32'h3);
      ap(1'b0, sfspi_pkg::REG_STATUS, 32'h0);
      `CK(q[7], 1'b0)
      chk(sfspi_pkg::REG_RXDATA, 32'h0);
      chk(sfspi_pkg::REG_RXDATA, 32'h1);
      repeat (40) ap(1'b0, sfspi_pkg::REG_RXDATA, 32'h0);
      m_u.sel(1'b0);
      m_u.xb(8'h0b, rs, ri);
      `CK(so_oe_n, 1'b0)
      // Pause in the data phase, so the output really has to let go
      hold_n <= 1'b0;
      m_u.tick(12);
      ap(1'b0, sfspi_pkg::REG_STATUS, 32'h0);
      `CK({q[1], so_oe_n}, 2'h3)
      m_u.xb(8'h33, rs, ri);
      m_u.sel(1'b1);
      hold_n <= 1'b1;
      chk(sfspi_pkg::REG_RXDATA, 32'h0b);
      chk(sfspi_pkg::REG_RXDATA, 32'h0);
      m_u.sel(1'b0);
      m_u.xb(8'h01, rs, ri);
      m_u.xb(8'h84, rs, ri);
      m_u.sel(1'b1);
      chk(sfspi_pkg::REG_SREG, 32'h84);
      wp_n <= 1'b0;
      m_u.tick(5);
      `CK(hw_lk, 1'b1)
      ap(1'b1, sfspi_pkg::REG_SREG, 32'h0);
      m_u.sel(1'b0);
      m_u.xb(8'h01, rs, ri);
      m_u.xb(8'h00, rs, ri);
      m_u.sel(1'b1);
      chk(sfspi_pkg::REG_SREG, 32'h84);
      wp_n <= 1'b1;
      ap(1'b1, sfspi_pkg::REG_SREG, 32'h3c);
      chk(sfspi_pkg::REG_SREG, 32'h3c);
      // Reset in mid-run brings the protection bits back to their reset values
      presetn <= 1'b0;
      m_u.tick(2);
      presetn <= 1'b1;
      chk(sfspi_pkg::REG_SREG, 32'h0);
      core_busy <= 1'b1;
      m_u.tick(2);
      `CK(standby, 1'b0)
      core_busy <= 1'b0;
      m_u.tick(5);
      `CK(standby, 1'b1)
      ap(1'b1, sfspi_pkg::REG_TXDATA, 32'h96);
      m_u.sel(1'b0);
      m_u.xb(8'h3b, rs, ri);
      repeat (5) m_u.xb(8'h00, rs, ri);
      // Pairs of 96 then idle fill: odd bits on the output pin, even bits on the input pin
      `CK({rs, ri, io0_oe_n}, {8'h9f, 8'h6f, 1'b0})
      m_u.sel(1'b1);
      `CK({io0_oe_n, so_oe_n}, 2'h3)
      test_done();
   end
endmodule
